// ### tmo_cfg.svh
`ifndef TMO_CFG_SVH
`define TMO_CFG_SVH

// Memory file count and the first legal file number.
`define TMO_FILES      10
`define TMO_FILE_MIN   4'h1
// Words of settings per test type and number of checked value kinds.
`define TMO_WN         5
`define TMO_IN         4
`define TMO_KINDS      9

// Command opcodes.
`define TMO_OP_LOAD    4'h1
`define TMO_OP_SAVE    4'h2
`define TMO_OP_CLEAR   4'h3
`define TMO_OP_QUERY   4'h4
`define TMO_OP_OPTSET  4'h5
`define TMO_OP_OPTQRY  4'h6

// Register byte offsets.
`define TMO_A_CMD      8'h00
`define TMO_A_STAT     8'h04
`define TMO_A_OPTSTG   8'h08
`define TMO_A_OPTACT   8'h0c
`define TMO_A_CHK      8'h10
`define TMO_A_WITH     8'h20
`define TMO_A_INS      8'h40
`define TMO_A_REPLY    8'h60
`define TMO_A_STEP     8'h04

// Value formats: {integer ok, decimal ok, least digits, most digits}.
`define TMO_F_WV       8'h53
`define TMO_F_WL       8'hd3
`define TMO_F_IV       8'h8c
`define TMO_F_IL       8'hdc
`define TMO_F_WC       8'hcb
`define TMO_F_RNG      8'h52
`define TMO_F_TIM      8'hd3
`define TMO_F_ELAP     8'h54
`define TMO_F_OTH      8'h89

// Insulation reply bounds in hundredths.
`define TMO_LIM_MIN    18'h00014
`define TMO_LIM_MAX    18'h30d40
`define TMO_TIM_MIN    18'h00032
`define TMO_TIM_MAX    18'h1863c

// Option field limits.
`define TMO_OPT_N      11
`define TMO_OPT_BINMAX 2'h1
`define TMO_OPT_ENDMAX 2'h2
`define TMO_REPLY_OPT  4'h1

`endif

// ### tmo_pkg.sv
package tmo_pkg;
`include "tmo_cfg.svh"

   // One setting: decimals, digit count and magnitude in hundredths.
   typedef struct packed {
      logic [1:0]  dec;
      logic [2:0]  dig;
      logic [17:0] mag;
   } tmo_val_t;

   typedef struct packed {
      logic       nr1;
      logic       nr2;
      logic [2:0] mn;
      logic [2:0] mx;
   } tmo_fmt_t;

   typedef enum logic [3:0] {
      TMO_LOAD   = `TMO_OP_LOAD,
      TMO_SAVE   = `TMO_OP_SAVE,
      TMO_CLEAR  = `TMO_OP_CLEAR,
      TMO_QUERY  = `TMO_OP_QUERY,
      TMO_OPTSET = `TMO_OP_OPTSET,
      TMO_OPTQRY = `TMO_OP_OPTQRY
   } tmo_op_t;

   typedef struct packed {
      logic       is_ins;
      logic [3:0] file;
      tmo_op_t    op;
   } tmo_cmd_t;

   // Field one sits in the low bits, field eleven in the high bits.
   typedef struct packed {
      logic [1:0] end_mode;
      logic [1:0] auto_range;
      logic [1:0] cmp_at_end;
      logic [1:0] interlock;
      logic [1:0] rs_start;
      logic [1:0] fail_mode;
      logic [1:0] two_step;
      logic [1:0] momentary;
      logic [1:0] gen_hold;
      logic [1:0] fail_hold;
      logic [1:0] pass_hold;
   } tmo_opt_t;

   typedef struct packed {
      logic [3:0] kind;
      tmo_val_t   v;
   } tmo_chk_t;

   typedef struct packed {
      logic [3:0] last_op;
      logic [3:0] reply_cnt;
      logic       set_fmt_err;
      logic       chk_pass;
      logic       ins_rdy;
      logic       with_rdy;
      logic       err;
      logic       ok;
   } tmo_stat_t;

endpackage

// ### tmo_cmd.sv
`include "tmo_cfg.svh"

// Operation
// - Memory commands fail with execution error unless that test type is ready.
// - File number must be 1 to 10, otherwise execution error.
// - Load copies the selected file into the active settings of that type.
// - Save writes active settings of that type into the selected file.
// - Clear returns the selected file to its reset contents.
// - Insulation query replies voltage, upper, lower, time; off reads zero.
// - Insulation reply limits lie in 0.2..2000, time in 0.5..999.
// - Option fields one to three are pass, fail and general hold flags.
// - Option fields four to eight enable momentary, two-step, fail, remote start, interlock.
// - Option field nine picks comparison at test start or test end.
// - Option field ten picks fixed or automatic insulation ranging.
// - Option field eleven picks set time, stop at pass, or stop at fail.
// - Option set fails when not ready or any field value is undefined.
// - Option query replies fields in the same order and encoding.
// - Sent and replied numbers follow the display format without spaces.
// - Withstand test and measured voltage are decimal, two or three digits.
// - Insulation test and measured voltage are integers of one to four digits.
// - Insulation limits and resistance use three or four digits, either form.
// - Withstand current uses one to three digits; output range two decimal digits.
// - Elapsed time is decimal of two to four digits; others one digit.
// - State report shows readiness separately for each test type.
module tmo_cmd #(
   parameter int AW    = 8,
   parameter int NFILE = `TMO_FILES
) (
   // Clock and reset.
   input  wire logic             clk_in,
   input  wire logic             srst_in,
   // Register port.
   input  wire logic [AW-1:0]    addr_in,
   input  wire logic [31:0]      wdata_in,
   input  wire logic             wr_in,
   input  wire logic             rd_in,
   output logic      [31:0]      rdata_out,
   // Tester state.
   input  wire logic             with_ready_in,
   input  wire logic             ins_ready_in,
   // Command outcome and option settings.
   output logic                  ack_out,
   output logic                  exec_err_out,
   output tmo_pkg::tmo_opt_t     opt_out
);
   import tmo_pkg::*;

   localparam tmo_fmt_t WFMT [`TMO_WN] = '{`TMO_F_WV, `TMO_F_WL, `TMO_F_WL,
                                           `TMO_F_TIM, `TMO_F_RNG};
   localparam tmo_fmt_t IFMT [`TMO_IN] = '{`TMO_F_IV, `TMO_F_IL, `TMO_F_IL,
                                           `TMO_F_TIM};
   localparam tmo_fmt_t KFMT [`TMO_KINDS] = '{`TMO_F_WV, `TMO_F_WL, `TMO_F_IV,
                                              `TMO_F_IL, `TMO_F_WC, `TMO_F_RNG,
                                              `TMO_F_TIM, `TMO_F_ELAP, `TMO_F_OTH};

   tmo_val_t   with_act_reg [`TMO_WN];
   tmo_val_t   ins_act_reg  [`TMO_IN];
   tmo_val_t   with_mem_reg [NFILE][`TMO_WN];
   tmo_val_t   ins_mem_reg  [NFILE][`TMO_IN];
   logic [31:0] reply_reg   [`TMO_WN];
   logic [3:0] reply_cnt_reg;
   tmo_opt_t   opt_stg_reg;
   tmo_opt_t   opt_act_reg;
   logic       ok_reg;
   logic       err_reg;
   logic       ack_reg;
   logic       perr_reg;
   logic       chk_reg;
   logic       fmt_err_reg;
   logic [3:0] last_op_reg;
   logic [3:0] last_fidx_reg;
   logic [31:0] rdata_reg;

   tmo_cmd_t   cmd;
   tmo_chk_t   chk;
   tmo_stat_t  stat;
   logic       cmd_wr;
   logic       is_mem;
   logic       op_known;
   logic       rdy;
   logic       file_ok;
   logic [3:0] fidx;
   logic       opt_valid;
   logic       rng_ok;
   logic       cmd_err;
   logic       cmd_ok;
   tmo_val_t   sel_ins0;
   tmo_val_t   ins_act0;
   tmo_val_t   last_ins0;
   tmo_val_t   sel_with0;
   tmo_val_t   with_act0;
   tmo_val_t   last_with0;

   // A zero magnitude means the setting is off and is always shown as "0".
   function automatic logic fmt_ok(tmo_fmt_t f, tmo_val_t v);
      logic ok;
      ok = 1'b1;
      if (v.mag != 18'h0) begin
         ok = (v.dig >= f.mn) && (v.dig <= f.mx) &&
              ((v.dec == 2'h0) ? f.nr1 : f.nr2) && ({1'b0, v.dec} < v.dig);
      end
      return ok;
   endfunction

   function automatic logic in_rng(tmo_val_t v, logic [17:0] lo, logic [17:0] hi);
      return (v.mag == 18'h0) || ((v.mag >= lo) && (v.mag <= hi));
   endfunction

   // Command decode; the command word itself is never stored.
   assign cmd      = tmo_cmd_t'(wdata_in[$bits(tmo_cmd_t)-1:0]);
   assign chk      = tmo_chk_t'(wdata_in[$bits(tmo_chk_t)-1:0]);
   assign cmd_wr   = wr_in && (addr_in == AW'(`TMO_A_CMD));
   assign is_mem   = (cmd.op == TMO_LOAD) || (cmd.op == TMO_SAVE) ||
                     (cmd.op == TMO_CLEAR) || (cmd.op == TMO_QUERY);
   assign op_known = is_mem || (cmd.op == TMO_OPTSET) || (cmd.op == TMO_OPTQRY);
   assign rdy      = cmd.is_ins ? ins_ready_in : with_ready_in;
   assign file_ok  = (cmd.file >= `TMO_FILE_MIN) &&
                     (cmd.file <= 4'(NFILE));
   assign fidx     = file_ok ? 4'(cmd.file - `TMO_FILE_MIN) : 4'h0;
   assign sel_ins0 = ins_mem_reg[fidx][0];
   assign ins_act0 = ins_act_reg[0];
   assign last_ins0 = ins_mem_reg[last_fidx_reg][0];
   assign sel_with0  = with_mem_reg[fidx][0];
   assign with_act0  = with_act_reg[0];
   assign last_with0 = with_mem_reg[last_fidx_reg][0];

   // Each option digit is a one-bit choice except the termination mode.
   always_comb begin
      logic [2*`TMO_OPT_N-1:0] f;
      f = opt_stg_reg;
      opt_valid = (opt_stg_reg.end_mode <= `TMO_OPT_ENDMAX);
      for (int k = 0; k < `TMO_OPT_N - 1; k++) begin
         if (f[2*k +: 2] > `TMO_OPT_BINMAX) begin
            opt_valid = 1'b0;
         end
      end
   end

   // A stored file that breaks the reply bounds is refused, not clamped.
   assign rng_ok = in_rng(ins_mem_reg[fidx][1], `TMO_LIM_MIN, `TMO_LIM_MAX) &&
                   in_rng(ins_mem_reg[fidx][2], `TMO_LIM_MIN, `TMO_LIM_MAX) &&
                   in_rng(ins_mem_reg[fidx][3], `TMO_TIM_MIN, `TMO_TIM_MAX);

   // Any failed check makes the whole command an execution error.
   assign cmd_err = !op_known ||
                    (is_mem && !rdy) ||
                    (is_mem && !file_ok) ||
                    ((cmd.op == TMO_OPTSET) &&
                     !(with_ready_in || ins_ready_in)) ||
                    ((cmd.op == TMO_OPTSET) && !opt_valid) ||
                    ((cmd.op == TMO_QUERY) && cmd.is_ins && !rng_ok);
   assign cmd_ok  = cmd_wr && !cmd_err;

   // Outcome pulses and last-result status; software never clears these.
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         ack_reg       <= 1'b0;
         perr_reg      <= 1'b0;
         ok_reg        <= 1'b0;
         err_reg       <= 1'b0;
         last_op_reg   <= 4'h0;
         last_fidx_reg <= 4'h0;
      end else begin
         ack_reg  <= cmd_ok;
         perr_reg <= cmd_wr && cmd_err;
         if (cmd_wr) begin
            ok_reg      <= !cmd_err;
            err_reg     <= cmd_err;
            last_op_reg <= cmd.op;
         end
         if (cmd_ok) begin
            last_fidx_reg <= fidx;
         end
      end
   end

   // Active settings: loaded from a file or written through the port.
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         for (int i = 0; i < `TMO_WN; i++) with_act_reg[i] <= '0;
         for (int i = 0; i < `TMO_IN; i++) ins_act_reg[i] <= '0;
         fmt_err_reg <= 1'b0;
      end else begin
         if (cmd_ok && (cmd.op == TMO_LOAD)) begin
            if (cmd.is_ins) begin
               for (int i = 0; i < `TMO_IN; i++) begin
                  ins_act_reg[i] <= ins_mem_reg[fidx][i];
               end
            end else begin
               for (int i = 0; i < `TMO_WN; i++) begin
                  with_act_reg[i] <= with_mem_reg[fidx][i];
               end
            end
         end
         // A badly formatted value is dropped and flagged until the next withstand or insulation setting write.
         for (int i = 0; i < `TMO_WN; i++) begin
            if (wr_in && (addr_in == AW'(`TMO_A_WITH + `TMO_A_STEP * i))) begin
               fmt_err_reg <= !fmt_ok(WFMT[i], wdata_in[$bits(tmo_val_t)-1:0]);
               if (fmt_ok(WFMT[i], wdata_in[$bits(tmo_val_t)-1:0])) begin
                  with_act_reg[i] <= wdata_in[$bits(tmo_val_t)-1:0];
               end
            end
         end
         for (int i = 0; i < `TMO_IN; i++) begin
            if (wr_in && (addr_in == AW'(`TMO_A_INS + `TMO_A_STEP * i))) begin
               fmt_err_reg <= !fmt_ok(IFMT[i], wdata_in[$bits(tmo_val_t)-1:0]);
               if (fmt_ok(IFMT[i], wdata_in[$bits(tmo_val_t)-1:0])) begin
                  ins_act_reg[i] <= wdata_in[$bits(tmo_val_t)-1:0];
               end
            end
         end
      end
   end

   // Memory files; cleared files hold the same all-off pattern as reset.
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         for (int f = 0; f < NFILE; f++) begin
            for (int i = 0; i < `TMO_WN; i++) with_mem_reg[f][i] <= '0;
            for (int i = 0; i < `TMO_IN; i++) ins_mem_reg[f][i] <= '0;
         end
      end else if (cmd_ok && cmd.is_ins) begin
         for (int i = 0; i < `TMO_IN; i++) begin
            if (cmd.op == TMO_SAVE) ins_mem_reg[fidx][i] <= ins_act_reg[i];
            if (cmd.op == TMO_CLEAR) ins_mem_reg[fidx][i] <= '0;
         end
      end else if (cmd_ok) begin
         for (int i = 0; i < `TMO_WN; i++) begin
            if (cmd.op == TMO_SAVE) with_mem_reg[fidx][i] <= with_act_reg[i];
            if (cmd.op == TMO_CLEAR) with_mem_reg[fidx][i] <= '0;
         end
      end
   end

   // Options: staged by the port, made active only by a valid set command.
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         opt_stg_reg <= '0;
         opt_act_reg <= '0;
      end else begin
         if (wr_in && (addr_in == AW'(`TMO_A_OPTSTG))) begin
            opt_stg_reg <= wdata_in[$bits(tmo_opt_t)-1:0];
         end
         if (cmd_ok && (cmd.op == TMO_OPTSET)) begin
            opt_act_reg <= opt_stg_reg;
         end
      end
   end
   assign opt_out = opt_act_reg;

   // Reply words; a failed command zeroes the reply count and keeps the old words.
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         for (int i = 0; i < `TMO_WN; i++) reply_reg[i] <= '0;
         reply_cnt_reg <= 4'h0;
      end else if (cmd_wr && cmd_err) begin
         reply_cnt_reg <= 4'h0;
      end else if (cmd_ok && (cmd.op == TMO_QUERY) && cmd.is_ins) begin
         for (int i = 0; i < `TMO_IN; i++) begin
            reply_reg[i] <= 32'(ins_mem_reg[fidx][i]);
         end
         reply_cnt_reg <= 4'(`TMO_IN);
      end else if (cmd_ok && (cmd.op == TMO_QUERY)) begin
         for (int i = 0; i < `TMO_WN; i++) begin
            reply_reg[i] <= 32'(with_mem_reg[fidx][i]);
         end
         reply_cnt_reg <= 4'(`TMO_WN);
      end else if (cmd_ok && (cmd.op == TMO_OPTQRY)) begin
         reply_reg[0]  <= 32'(opt_act_reg);
         reply_cnt_reg <= `TMO_REPLY_OPT;
      end
   end

   // Format checker for measured and miscellaneous values.
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         chk_reg <= 1'b0;
      end else if (wr_in && (addr_in == AW'(`TMO_A_CHK))) begin
         chk_reg <= (chk.kind < 4'(`TMO_KINDS)) &&
                    fmt_ok(KFMT[chk.kind], chk.v);
      end
   end

   // Readiness is reported per test type.
   assign stat = '{last_op: last_op_reg, reply_cnt: reply_cnt_reg,
                   set_fmt_err: fmt_err_reg, chk_pass: chk_reg,
                   ins_rdy: ins_ready_in, with_rdy: with_ready_in,
                   err: err_reg, ok: ok_reg};

   // Read data stand one cycle after the strobe; unmapped offsets read zero.
   always_ff @(posedge clk_in) begin
      if (srst_in || !rd_in) begin
         rdata_reg <= 32'h0;
      end else begin
         rdata_reg <= 32'h0;
         if (addr_in == AW'(`TMO_A_STAT)) rdata_reg <= 32'(stat);
         if (addr_in == AW'(`TMO_A_OPTSTG)) rdata_reg <= 32'(opt_stg_reg);
         if (addr_in == AW'(`TMO_A_OPTACT)) rdata_reg <= 32'(opt_act_reg);
         if (addr_in == AW'(`TMO_A_CHK)) rdata_reg <= 32'(chk_reg);
         for (int i = 0; i < `TMO_WN; i++) begin
            if (addr_in == AW'(`TMO_A_WITH + `TMO_A_STEP * i)) begin
               rdata_reg <= 32'(with_act_reg[i]);
            end
            if (addr_in == AW'(`TMO_A_REPLY + `TMO_A_STEP * i)) begin
               rdata_reg <= reply_reg[i];
            end
         end
         for (int i = 0; i < `TMO_IN; i++) begin
            if (addr_in == AW'(`TMO_A_INS + `TMO_A_STEP * i)) begin
               rdata_reg <= 32'(ins_act_reg[i]);
            end
         end
      end
   end
   assign rdata_out    = rdata_reg;
   assign ack_out      = ack_reg;
   assign exec_err_out = perr_reg;

   // Checks on the command outcome.
   rdy_err_a: assert property (@(posedge clk_in) disable iff (srst_in)
      cmd_wr && is_mem && !rdy |=> exec_err_out && !ack_out)
      else $error("memory command ran while not ready");
   file_rng_a: assert property (@(posedge clk_in) disable iff (srst_in)
      cmd_wr && is_mem && !file_ok |=> exec_err_out ##1 !exec_err_out || $past(cmd_wr))
      else $error("bad file number accepted");
   load_copy_a: assert property (@(posedge clk_in) disable iff (srst_in)
      cmd_ok && (cmd.op == TMO_LOAD) && cmd.is_ins |=> ins_act0 == $past(sel_ins0))
      else $error("load did not copy file");
   save_copy_a: assert property (@(posedge clk_in) disable iff (srst_in)
      cmd_ok && (cmd.op == TMO_SAVE) && cmd.is_ins |=> last_ins0 == $past(ins_act0))
      else $error("save did not store settings");
   clear_zero_a: assert property (@(posedge clk_in) disable iff (srst_in)
      cmd_ok && (cmd.op == TMO_CLEAR) && cmd.is_ins |=> last_ins0 == '0)
      else $error("clear left data in file");
   ins_reply_a: assert property (@(posedge clk_in) disable iff (srst_in)
      cmd_ok && (cmd.op == TMO_QUERY) && cmd.is_ins |=>
      (reply_cnt_reg == 4'(`TMO_IN)) && (reply_reg[0] == 32'($past(sel_ins0))))
      else $error("insulation reply wrong");
   ins_bound_a: assert property (@(posedge clk_in) disable iff (srst_in)
      cmd_wr && (cmd.op == TMO_QUERY) && cmd.is_ins && !rng_ok |=>
      exec_err_out && (reply_cnt_reg == 4'h0))
      else $error("out of range file replied");
   opt_set_a: assert property (@(posedge clk_in) disable iff (srst_in)
      cmd_ok && (cmd.op == TMO_OPTSET) |=> opt_out == $past(opt_stg_reg) ##1 ack_out == 1'b0 || $past(cmd_ok))
      else $error("option set not applied");
   opt_bad_a: assert property (@(posedge clk_in) disable iff (srst_in)
      cmd_wr && (cmd.op == TMO_OPTSET) && !opt_valid |=> exec_err_out && $stable(opt_out))
      else $error("invalid option accepted");
   opt_query_a: assert property (@(posedge clk_in) disable iff (srst_in)
      cmd_ok && (cmd.op == TMO_OPTQRY) |=> reply_reg[0] == 32'(opt_out))
      else $error("option reply differs");
   fmt_rej_a: assert property (@(posedge clk_in) disable iff (srst_in)
      wr_in && (addr_in == AW'(`TMO_A_INS)) &&
      !fmt_ok(IFMT[0], wdata_in[$bits(tmo_val_t)-1:0]) |=> $stable(ins_act0) && fmt_err_reg)
      else $error("bad format stored");
   ack_ok_a: assert property (@(posedge clk_in) disable iff (srst_in)
      ack_out |-> !exec_err_out && $past(cmd_wr))
      else $error("ack without good command");
   // Withstand path and undecoded opcodes.
   with_load_a: assert property (@(posedge clk_in) disable iff (srst_in)
      cmd_ok && (cmd.op == TMO_LOAD) && !cmd.is_ins |=> with_act0 == $past(sel_with0))
      else $error("withstand load did not copy file");
   with_save_a: assert property (@(posedge clk_in) disable iff (srst_in)
      cmd_ok && (cmd.op == TMO_SAVE) && !cmd.is_ins |=> last_with0 == $past(with_act0))
      else $error("withstand save did not store");
   with_clear_a: assert property (@(posedge clk_in) disable iff (srst_in)
      cmd_ok && (cmd.op == TMO_CLEAR) && !cmd.is_ins |=> last_with0 == '0)
      else $error("withstand clear left data");
   with_fmt_a: assert property (@(posedge clk_in) disable iff (srst_in)
      wr_in && (addr_in == AW'(`TMO_A_WITH)) &&
      !fmt_ok(WFMT[0], wdata_in[$bits(tmo_val_t)-1:0]) |=> $stable(with_act0) && fmt_err_reg)
      else $error("bad withstand format stored");
   op_unknown_a: assert property (@(posedge clk_in) disable iff (srst_in)
      cmd_wr && !op_known |=> exec_err_out && !ack_out)
      else $error("unknown opcode accepted");
endmodule

// ### tmo_host.sv
// Host model: drives the register port one strobe cycle at a time.
module tmo_host (
   // Clock.
   input  wire logic        clk_in,
   // Register port towards the command block.
   output logic      [7:0]  addr_out,
   output logic      [31:0] wdata_out,
   output logic             wr_out,
   output logic             rd_out,
   input  wire logic [31:0] rdata_in
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus at time zero.
   initial begin
      addr_out  = 8'h00;
      wdata_out = 32'h0;
      wr_out    = 1'b0;
      rd_out    = 1'b0;
   end

   // One write cycle; data is inverted once released so stale values never match.
   task automatic wr_t(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_out  <= a;
      wdata_out <= d;
      wr_out    <= 1'b1;
      @(posedge clk_in);
      wr_out    <= 1'b0;
      wdata_out <= ~d;
      #1;
   endtask

   // One read cycle; data is taken in the cycle after the strobe, the only valid one.
   task automatic rd_t(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out   <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      #1;
      d = rdata_in;
   endtask

   // File numbers that a well-behaved host sends.
   function automatic logic file_ok(input logic [3:0] f);
      return f >= 4'h1 && f <= 4'ha;
   endfunction
endmodule

// ### tester_memory_option_commands_tb_top.sv
`include "tmo_cfg.svh"
module tester_memory_option_commands_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import tmo_pkg::*;

   logic        clk_in = 1'b0;
   logic        srst_in;
   logic        with_ready;
   logic        ins_ready;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic        ack;
   logic        err;
   tmo_opt_t    opt;
   tmo_opt_t    o;
   logic [31:0] d;
   int          fail_count = 0;
   int          tests_run = 0;
   int          cycles = 0;
   // Insulation settings: 1000 V, upper off, lower 100.0, time 5.0.
   logic [31:0] w[4] = '{32'h001186a0, 32'h0, 32'h00302710, 32'h002801f4};
   // Check words, a passing and a failing one for kinds 0, 2 to 5, 7 and 8, then three of an unknown kind.
   logic [31:0] cw[17] = '{32'h004c0096, 32'h000c0096, 32'h011186a0, 32'h013186a0,
      32'h01b02710, 32'h018807d0, 32'h024c00c8, 32'h025007d0, 32'h02a800fa,
      32'h028809c4, 32'h03ac0bb8, 32'h03880bb8, 32'h04040064, 32'h040803e8,
      32'h04840064, 32'h04840064, 32'h04840064};
   // Withstand file: 1.20 kV, upper 5.0, lower off, 20.0 s, range 2.5.
   logic [31:0] ww[5] = '{32'h004c0078, 32'h002801f4, 32'h0, 32'h002c07d0, 32'h002800fa};

   // Free-running 125 MHz clock.
   always #4 clk_in = ~clk_in;

   tmo_host host (.clk_in(clk_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
      .rd_out(rd), .rdata_in(rdata));

   tmo_cmd uut (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .with_ready_in(with_ready),
      .ins_ready_in(ins_ready), .ack_out(ack), .exec_err_out(err), .opt_out(opt));

   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic rdc(string name, logic [7:0] a, logic [31:0] exp);
      logic [31:0] v;
      host.rd_t(a, v);
      chk(name, v, exp);
   endtask

   // Issue one command; exactly one outcome pulse must follow.
   task automatic cmd(logic [3:0] op, logic [3:0] f, logic ins, logic good);
      host.wr_t(`TMO_A_CMD, {23'h0, ins, f, op});
      chk("ack", {31'h0, ack}, {31'h0, good});
      chk("err", {31'h0, err}, {31'h0, !good});
   endtask

   // Ready levels change one edge ahead of the next request.
   task automatic rdy(logic wv, logic iv);
      @(posedge clk_in);
      with_ready <= wv;
      ins_ready  <= iv;
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Hang guard, well above the few hundred cycles the sequence needs.
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         wrap_up();
      end
   end

   // Main sequence.
   initial begin
      srst_in    = 1'b1;
      with_ready = 1'b0;
      ins_ready  = 1'b0;
      repeat (8) @(posedge clk_in);
      srst_in <= 1'b0;
      rdc("opt act", `TMO_A_OPTACT, 32'h0);
      rdc("unmapped", 8'hfc, 32'h0);
      chk("opt_out", {10'h0, opt}, 32'h0);
      $display("test reset done");
      rdy(1'b1, 1'b0);
      rdc("stat", `TMO_A_STAT, 32'h4);
      cmd(`TMO_OP_SAVE, 4'h1, 1'b1, 1'b0);
      cmd(`TMO_OP_QUERY, 4'h1, 1'b1, 1'b0);
      rdy(1'b0, 1'b1);
      cmd(`TMO_OP_LOAD, 4'h1, 1'b0, 1'b0);
      cmd(`TMO_OP_CLEAR, 4'h1, 1'b0, 1'b0);
      rdc("stat", `TMO_A_STAT, 32'hc0a);
      for (int f = 0; f < 16; f++) begin
         cmd(`TMO_OP_CLEAR, 4'(f), 1'b1, host.file_ok(4'(f)));
      end
      $display("test ready and file range done");
      // Save twice so the second must replace the first, then reload.
      cmd(`TMO_OP_SAVE, 4'h2, 1'b1, 1'b1);
      for (int i = 0; i < 4; i++) host.wr_t(`TMO_A_INS + 8'(4 * i), w[i]);
      cmd(`TMO_OP_SAVE, 4'h2, 1'b1, 1'b1);
      for (int i = 0; i < 4; i++) host.wr_t(`TMO_A_INS + 8'(4 * i), 32'h0);
      cmd(`TMO_OP_LOAD, 4'h2, 1'b1, 1'b1);
      for (int i = 0; i < 4; i++) rdc("active", `TMO_A_INS + 8'(4 * i), w[i]);
      cmd(`TMO_OP_QUERY, 4'h2, 1'b1, 1'b1);
      for (int i = 0; i < 4; i++) rdc("reply", `TMO_A_REPLY + 8'(4 * i), w[i]);
      rdc("stat", `TMO_A_STAT, 32'h1109);
      cmd(`TMO_OP_CLEAR, 4'h2, 1'b1, 1'b1);
      cmd(`TMO_OP_QUERY, 4'h2, 1'b1, 1'b1);
      for (int i = 0; i < 4; i++) rdc("cleared", `TMO_A_REPLY + 8'(4 * i), 32'h0);
      $display("test memory files done");
      // Limits at both edges of the reply range, then a lower limit of 0.10, below it.
      host.wr_t(`TMO_A_INS + 8'h04, 32'h00130d40);
      host.wr_t(`TMO_A_INS + 8'h08, 32'h004c0014);
      cmd(`TMO_OP_SAVE, 4'h5, 1'b1, 1'b1);
      cmd(`TMO_OP_QUERY, 4'h5, 1'b1, 1'b1);
      rdc("upper", `TMO_A_REPLY + 8'h04, 32'h00130d40);
      host.wr_t(`TMO_A_INS + 8'h08, 32'h004c000a);
      cmd(`TMO_OP_SAVE, 4'h4, 1'b1, 1'b1);
      cmd(`TMO_OP_QUERY, 4'h4, 1'b1, 1'b0);
      // A decimal insulation voltage is refused and flagged.
      host.wr_t(`TMO_A_INS, 32'h003186a0);
      rdc("ins volt", `TMO_A_INS, w[0]);
      host.rd_t(`TMO_A_STAT, d);
      chk("fmt err", {31'h0, d[5]}, 32'h1);
      for (int i = 0; i < 17; i++) begin
         host.wr_t(`TMO_A_CHK, cw[i]);
         rdc("check", `TMO_A_CHK, {31'h0, i < 14 && i % 2 == 0});
      end
      $display("test formats done");
      // Example option string 01000010001.
      o = '0;
      o.fail_hold = 2'h1;
      o.rs_start = 2'h1;
      o.end_mode = 2'h1;
      host.wr_t(`TMO_A_OPTSTG, {10'h0, o});
      rdy(1'b0, 1'b0);
      cmd(`TMO_OP_OPTSET, 4'h1, 1'b0, 1'b0);
      chk("opt_out", {10'h0, opt}, 32'h0);
      rdy(1'b1, 1'b0);
      cmd(`TMO_OP_OPTSET, 4'h1, 1'b0, 1'b1);
      chk("opt_out", {10'h0, opt}, {10'h0, o});
      rdc("opt act", `TMO_A_OPTACT, {10'h0, o});
      rdy(1'b0, 1'b0);
      cmd(`TMO_OP_OPTQRY, 4'h1, 1'b0, 1'b1);
      rdc("opt reply", `TMO_A_REPLY, {10'h0, o});
      rdy(1'b0, 1'b1);
      // Each field at its top value, then one past it, which must be refused.
      for (int i = 0; i < 11; i++) begin
         o = '0;
         o[2 * i +: 2] = (i == 10) ? 2'h2 : 2'h1;
         host.wr_t(`TMO_A_OPTSTG, {10'h0, o});
         cmd(`TMO_OP_OPTSET, 4'h1, 1'b0, 1'b1);
         chk("opt field", {10'h0, opt}, {10'h0, o});
         host.wr_t(`TMO_A_OPTSTG, {10'h0, o} + (32'h1 << (2 * i)));
         cmd(`TMO_OP_OPTSET, 4'h1, 1'b0, 1'b0);
         chk("opt kept", {10'h0, opt}, {10'h0, o});
      end
      $display("test options done");
      // Withstand path: a bad write is dropped, then save, reload and query.
      rdy(1'b1, 1'b0);
      for (int i = 0; i < 5; i++) host.wr_t(`TMO_A_WITH + 8'(4 * i), ww[i]);
      host.wr_t(`TMO_A_WITH, 32'h00040078);
      rdc("with volt", `TMO_A_WITH, ww[0]);
      cmd(`TMO_OP_SAVE, 4'h3, 1'b0, 1'b1);
      cmd(`TMO_OP_LOAD, 4'h1, 1'b0, 1'b1);
      cmd(`TMO_OP_LOAD, 4'h3, 1'b0, 1'b1);
      for (int i = 0; i < 5; i++) rdc("with act", `TMO_A_WITH + 8'(4 * i), ww[i]);
      cmd(`TMO_OP_QUERY, 4'h3, 1'b0, 1'b1);
      for (int i = 0; i < 5; i++) rdc("with reply", `TMO_A_REPLY + 8'(4 * i), ww[i]);
      rdc("stat", `TMO_A_STAT, 32'h1165);
      cmd(`TMO_OP_CLEAR, 4'h3, 1'b0, 1'b1);
      cmd(4'h7, 4'h3, 1'b0, 1'b0);
      $display("test withstand files done");
      wrap_up();
   end
endmodule
